// ===== design/rpm_in_cell.sv
// one remappable input: two-stage synchroniser, then inversion
// assumes the pin level already resolved by the analog sense stage
`timescale 1ns/100ps
`default_nettype none
module rpm_in_cell (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // pin and setting
  input  wire logic pin_raw,
  input  wire logic invert,
  // resolved level
  output logic      level_q
);

  logic       sync_a_q;  // first stage, read only by sync_b_q
  logic       sync_b_q;  // second stage
  logic [1:0] warm_q;    // helper: edges since reset, held at 3

  // synchroniser then inversion, so inversion never meets a metastable bit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_a_q <= 1'b0;
      sync_b_q <= 1'b0;
      level_q  <= 1'b0;
    end else begin
      sync_a_q <= pin_raw;
      sync_b_q <= sync_a_q;
      level_q  <= sync_b_q ^ invert;
    end
  end

  // helper counter so the check skips the pipeline fill
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      warm_q <= 2'h0;
    end else if (warm_q != 2'h3) begin
      warm_q <= warm_q + 2'h1;
    end
  end

  AST_IN_SYNC_INV: assert property (@(posedge sys_clk) disable iff (rst)
    (warm_q == 2'h3) |-> (level_q == ($past(pin_raw, 3) ^ $past(invert))))
    else $error("input level not raw delayed three cycles xor invert");

endmodule
`default_nettype wire

// ===== design/rpm_mux.sv
// remappable pin function mux: pin configs, function routing,
// protection latch and interrupt status
// assumes pins asynchronous inputs, pad logic resolves open-drain enables
`timescale 1ns/100ps
`default_nettype none
module rpm_mux #(
  parameter int NPROT = rpm_pkg::NPROT_DEF
) (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  // register port
  input  wire logic [7:0]                 reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [31:0]                reg_rdata,
  // input pins
  input  wire logic [rpm_pkg::NUM_IN-1:0] gpi_in,
  output logic      [rpm_pkg::NUM_IN-1:0] gpi_pullup_en,
  // output pins
  output logic      [rpm_pkg::NUM_OUT-1:0] gpo_o,
  output logic      [rpm_pkg::NUM_OUT-1:0] gpo_oe,
  // core logic side
  input  wire logic [NPROT-1:0]           prot_event,
  input  wire logic [NPROT-1:0]           prot_recover,
  input  wire logic                       charge_request,
  input  wire logic                       charging_active,
  output logic                            ignition_state,
  output logic                            mains_present_input,
  output logic                            prot_any,
  output logic                            charger_en,
  // interrupt
  output logic                            irq
);

  localparam int NI = rpm_pkg::NUM_IN;
  localparam int NO = rpm_pkg::NUM_OUT;
  localparam int FL = rpm_pkg::FN_LSB;
  localparam int FW = rpm_pkg::FN_W;

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [NI-1:0][rpm_pkg::IN_CFG_W-1:0]  in_cfg_q;    // per input pin
  logic [NO-1:0][rpm_pkg::OUT_CFG_W-1:0] out_cfg_q;   // per output pin
  logic [NPROT-1:0]                      prot_norec_q; // no auto recovery
  logic [NPROT-1:0]                      prot_act_q;  // active protections
  logic [NPROT-1:0]                      prot_act_d;
  logic [rpm_pkg::IRQ_W-1:0]             irq_stat_q;  // sticky events
  logic [rpm_pkg::IRQ_W-1:0]             irq_stat_d;
  logic [rpm_pkg::IRQ_W-1:0]             irq_en_q;    // interrupt enables
  logic                                  clr_prev_q;  // clear level, last cycle
  logic                                  ign_q;
  logic                                  mains_q;
  logic                                  prot_any_q;
  logic                                  chg_en_q;
  logic [31:0]                           rdata_q;
  logic [NI-1:0]                         pullup_q;

  ////////////////////////////////////////////////////////////////////////
  // address decode
  logic [7:0] out_off;   // offset inside the output config block
  logic [1:0] in_idx;    // addressed input pin
  logic [2:0] out_idx;   // addressed output pin
  logic       aligned;
  logic       in_hit;
  logic       out_hit;
  logic       norec_hit;
  logic       act_hit;
  logic       st_hit;
  logic       is_hit;
  logic       ic_hit;
  logic       ie_hit;
  logic       pc_hit;

  assign aligned   = (reg_addr[1:0] == 2'h0);
  assign out_off   = reg_addr - rpm_pkg::OUT_CFG0;
  assign in_idx    = reg_addr[3:2];
  assign out_idx   = out_off[4:2];
  assign in_hit    = aligned && (reg_addr <= rpm_pkg::IN_CFG_LAST);
  assign out_hit   = aligned && (reg_addr >= rpm_pkg::OUT_CFG0) && (reg_addr <= rpm_pkg::OUT_CFG_LAST);
  assign norec_hit = (reg_addr == rpm_pkg::PROT_NOREC);
  assign act_hit   = (reg_addr == rpm_pkg::PROT_ACTIVE);
  assign st_hit    = (reg_addr == rpm_pkg::FUNC_STATUS);
  assign is_hit    = (reg_addr == rpm_pkg::IRQ_STATUS);
  assign ic_hit    = (reg_addr == rpm_pkg::IRQ_CLEAR);
  assign ie_hit    = (reg_addr == rpm_pkg::IRQ_ENABLE);
  assign pc_hit    = (reg_addr == rpm_pkg::PROT_CLEAR);

  ////////////////////////////////////////////////////////////////////////
  // per pin: duplicate check, write enable, function selects
  logic [FW-1:0] wr_func;   // function code being written
  logic [NI-1:0] in_dup;    // another input already holds it
  logic [NO-1:0] out_dup;   // another output already holds it
  logic [NI-1:0] in_we;
  logic [NO-1:0] out_we;
  logic          in_reject;
  logic          out_reject;
  logic [NI-1:0] lvl;       // synchronised, inverted input levels
  logic [NI-1:0] ign_sel;
  logic [NI-1:0] mains_sel;
  logic [NI-1:0] clr_sel;
  logic [NO-1:0] ind_sel;
  logic [NO-1:0] en_sel;
  logic [NO-1:0] pind_sel;

  assign wr_func = reg_wdata[FL +: FW];

  // input pins carry only input codes, since every value of the 2-bit function field is one
  for (genvar i = 0; i < NI; i++) begin : g_in
    // a code of none never clashes, so pins can always be freed
    assign in_dup[i]    = (in_cfg_q[i][FL +: FW] == wr_func) && (in_idx != 2'(i))
                          && (wr_func != rpm_pkg::IN_NONE);
    assign in_we[i]     = reg_wr && in_hit && (in_idx == 2'(i)) && !in_reject;
    assign ign_sel[i]   = (in_cfg_q[i][FL +: FW] == rpm_pkg::IN_IGNITION);
    assign mains_sel[i] = (in_cfg_q[i][FL +: FW] == rpm_pkg::IN_MAINS);
    assign clr_sel[i]   = (in_cfg_q[i][FL +: FW] == rpm_pkg::IN_PROT_CLR);

    // whole word lands in one edge: function, inversion and sensing at once
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        in_cfg_q[i] <= rpm_pkg::IN_CFG_RST[i*rpm_pkg::IN_CFG_W +: rpm_pkg::IN_CFG_W];
      end else if (in_we[i]) begin
        in_cfg_q[i] <= reg_wdata[rpm_pkg::IN_CFG_W-1:0];
      end
    end

    // sync and inversion cell
    rpm_in_cell u_in (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pin_raw (gpi_in[i]),
      .invert  (in_cfg_q[i][rpm_pkg::INV_BIT]),
      .level_q (lvl[i])
    );
  end

  assign in_reject = |in_dup;

  for (genvar i = 0; i < NO; i++) begin : g_out
    logic func_on;  // function level for this pin
    assign out_dup[i]  = (out_cfg_q[i][FL +: FW] == wr_func) && (out_idx != 3'(i))
                         && (wr_func != rpm_pkg::OUT_NONE);
    assign out_we[i]   = reg_wr && out_hit && (out_idx == 3'(i)) && !out_reject;
    assign ind_sel[i]  = (out_cfg_q[i][FL +: FW] == rpm_pkg::OUT_CHG_IND);
    assign en_sel[i]   = (out_cfg_q[i][FL +: FW] == rpm_pkg::OUT_CHG_EN);
    assign pind_sel[i] = (out_cfg_q[i][FL +: FW] == rpm_pkg::OUT_PROT_IND);
    assign func_on     = (ind_sel[i] && charging_active)
                         || (en_sel[i] && chg_en_q)
                         || (pind_sel[i] && prot_any_q);

    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        out_cfg_q[i] <= rpm_pkg::OUT_CFG_RST[i*rpm_pkg::OUT_CFG_W +: rpm_pkg::OUT_CFG_W];
      end else if (out_we[i]) begin
        out_cfg_q[i] <= reg_wdata[rpm_pkg::OUT_CFG_W-1:0];
      end
    end

    // open-drain driver cell
    rpm_od_cell u_od (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .assigned (out_cfg_q[i][FL +: FW] != rpm_pkg::OUT_NONE),
      .func_on  (func_on),
      .invert   (out_cfg_q[i][rpm_pkg::INV_BIT]),
      .pin_o    (gpo_o[i]),
      .pin_oe_q (gpo_oe[i])
    );
  end

  assign out_reject = |out_dup;

  ////////////////////////////////////////////////////////////////////////
  // input function resolution; at most one select bit is set per function
  logic ign_d;
  logic mains_d;
  logic clr_lvl;
  logic clr_pulse;
  logic sw_clr;
  logic clr_all;

  assign ign_d     = |(ign_sel & lvl);
  assign mains_d   = |(mains_sel & lvl);
  assign clr_lvl   = |(clr_sel & lvl);
  assign clr_pulse = clr_lvl && !clr_prev_q;
  assign sw_clr    = reg_wr && pc_hit && reg_wdata[rpm_pkg::CLR_BIT];
  assign clr_all   = clr_pulse || sw_clr;

  // voltage sensing leaves the pull-up off so an open pin reads low,
  // ground sensing turns it on so an open pin reads high
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pullup_q <= '0;
    end else begin
      for (int i = 0; i < NI; i++) begin
        pullup_q[i] <= in_cfg_q[i][rpm_pkg::SENSE_BIT];
      end
    end
  end

  assign gpi_pullup_en = pullup_q;

  ////////////////////////////////////////////////////////////////////////
  // protection latch: a new event beats any clear in the same cycle
  logic [NPROT-1:0] clr_mask;

  assign clr_mask   = {NPROT{clr_all}} | (prot_recover & ~prot_norec_q);
  assign prot_act_d = (prot_act_q & ~clr_mask) | prot_event;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prot_act_q <= '0;
      prot_any_q <= 1'b0;
      chg_en_q   <= 1'b0;
    end else begin
      prot_act_q <= prot_act_d;
      prot_any_q <= |prot_act_d;
      chg_en_q   <= charge_request && !(|prot_act_d);
    end
  end

  // registered input function levels and clear edge history
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ign_q      <= 1'b0;
      mains_q    <= 1'b0;
      clr_prev_q <= 1'b0;
    end else begin
      ign_q      <= ign_d;
      mains_q    <= mains_d;
      clr_prev_q <= clr_lvl;
    end
  end

  assign ignition_state      = ign_q;
  assign mains_present_input = mains_q;
  assign prot_any            = prot_any_q;
  assign charger_en          = chg_en_q;

  ////////////////////////////////////////////////////////////////////////
  // interrupts: sticky status, set wins over clear
  logic [rpm_pkg::IRQ_W-1:0] irq_ev;
  logic [rpm_pkg::IRQ_W-1:0] irq_clr;

  assign irq_ev[rpm_pkg::IRQ_PROT_SET]  = |(prot_event & ~prot_act_q);
  assign irq_ev[rpm_pkg::IRQ_PIN_CLR]   = clr_pulse;
  assign irq_ev[rpm_pkg::IRQ_REJECT]    = reg_wr && ((in_hit && in_reject) || (out_hit && out_reject));
  assign irq_ev[rpm_pkg::IRQ_IGN_CHG]   = (ign_d != ign_q);
  assign irq_ev[rpm_pkg::IRQ_MAINS_CHG] = (mains_d != mains_q);
  assign irq_clr    = (reg_wr && ic_hit) ? reg_wdata[rpm_pkg::IRQ_W-1:0] : '0;
  assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_ev;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_stat_q   <= '0;
      irq_en_q     <= rpm_pkg::IRQ_EN_RST;
      prot_norec_q <= '0;
    end else begin
      irq_stat_q <= irq_stat_d;
      if (reg_wr && ie_hit) begin
        irq_en_q <= reg_wdata[rpm_pkg::IRQ_W-1:0];
      end
      if (reg_wr && norec_hit) begin
        prot_norec_q <= reg_wdata[NPROT-1:0];
      end
    end
  end

  // level output, high while an enabled status bit stands
  assign irq = |(irq_stat_q & irq_en_q);

  ////////////////////////////////////////////////////////////////////////
  // read path: data stands only in the cycle after the strobe
  logic [rpm_pkg::ST_W-1:0] func_st;
  logic [31:0]              rd_word;

  assign func_st = {chg_en_q, charging_active, prot_any_q, mains_q, ign_q};
  assign rd_word = in_hit    ? {{(32-rpm_pkg::IN_CFG_W){1'b0}}, in_cfg_q[in_idx]} :
                   out_hit   ? {{(32-rpm_pkg::OUT_CFG_W){1'b0}}, out_cfg_q[out_idx]} :
                   norec_hit ? {{(32-NPROT){1'b0}}, prot_norec_q} :
                   act_hit   ? {{(32-NPROT){1'b0}}, prot_act_q} :
                   st_hit    ? {{(32-rpm_pkg::ST_W){1'b0}}, func_st} :
                   is_hit    ? {{(32-rpm_pkg::IRQ_W){1'b0}}, irq_stat_q} :
                   ie_hit    ? {{(32-rpm_pkg::IRQ_W){1'b0}}, irq_en_q} :
                   32'h00000000;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= reg_rd ? rd_word : 32'h00000000;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_clr_edge;
    !clr_lvl ##1 (clr_lvl && !(|prot_event));
  endsequence

  sequence s_new_prot;
    (|prot_event) ##1 prot_any_q;
  endsequence

  AST_UNIQUE_IN: assert property (@(posedge sys_clk) disable iff (rst)
    $onehot0(ign_sel) && $onehot0(mains_sel) && $onehot0(clr_sel))
    else $error("input function mapped to more than one pin");

  AST_UNIQUE_OUT: assert property (@(posedge sys_clk) disable iff (rst)
    $onehot0(ind_sel) && $onehot0(en_sel) && $onehot0(pind_sel))
    else $error("output function mapped to more than one pin");

  AST_DUP_REJECT: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_wr && in_hit && in_reject) |=> ($stable(in_cfg_q) && irq_stat_q[rpm_pkg::IRQ_REJECT]))
    else $error("duplicate mapping write was not refused");

  AST_WRITE_APPLIES: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_wr && out_hit && !out_reject) |=>
      (out_cfg_q[$past(out_idx)] == $past(reg_wdata[rpm_pkg::OUT_CFG_W-1:0])))
    else $error("output pin setting not applied on the next edge");

  AST_PIN_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
    s_clr_edge |=> (prot_act_q == '0))
    else $error("clear input edge left a protection active");

  AST_NOREC_HOLDS: assert property (@(posedge sys_clk) disable iff (rst)
    !clr_all |=> ((prot_act_q & $past(prot_act_q & prot_norec_q)) == $past(prot_act_q & prot_norec_q)))
    else $error("non-recovering protection dropped without manual reset");

  AST_PROT_IND: assert property (@(posedge sys_clk) disable iff (rst)
    (|prot_event) |-> s_new_prot)
    else $error("protection indication missing after an event");

  AST_CHG_BLOCK: assert property (@(posedge sys_clk) disable iff (rst)
    prot_any_q |-> !chg_en_q)
    else $error("charger enabled while a protection is active");

  AST_RDATA_IDLE: assert property (@(posedge sys_clk) disable iff (rst)
    !reg_rd |=> (reg_rdata == 32'h00000000))
    else $error("read data present without a read strobe");

endmodule
`default_nettype wire

// ===== design/rpm_od_cell.sv
// one remappable output driven open-drain
// assumes an external pull-up; the pad resolves level from the enable
`timescale 1ns/100ps
`default_nettype none
module rpm_od_cell (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // function side
  input  wire logic assigned,
  input  wire logic func_on,
  input  wire logic invert,
  // pad side
  output logic      pin_o,
  output logic      pin_oe_q
);

  // data is always low: the pin is only ever pulled down
  assign pin_o = 1'b0;

  // pull low while the function level xor invert is set, release when unassigned
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_oe_q <= 1'b0;
    end else begin
      pin_oe_q <= assigned & (func_on ^ invert);
    end
  end

  AST_OD_NEVER_HIGH: assert property (@(posedge sys_clk) disable iff (rst)
    pin_o == 1'b0)
    else $error("open-drain output drove a high level");

  AST_OD_RELEASED: assert property (@(posedge sys_clk) disable iff (rst)
    !assigned |=> !pin_oe_q)
    else $error("unassigned output not released");

  AST_OD_FOLLOW: assert property (@(posedge sys_clk) disable iff (rst)
    assigned |=> (pin_oe_q == ($past(func_on) ^ $past(invert))))
    else $error("assigned output does not follow its function");

endmodule
`default_nettype wire

// ===== design/rpm_pkg.sv
// constants, field layout and function codes of the remappable pin mux
// assumes one system clock, registers reached over a plain strobe port

package rpm_pkg;

  ////////////////////////////////////////////////////////////////////////
  // pin counts
  localparam int NUM_IN    = 4;
  localparam int NUM_OUT   = 6;
  localparam int NPROT_DEF = 8;

  ////////////////////////////////////////////////////////////////////////
  // register byte offsets, one word each
  localparam logic [7:0] IN_CFG0      = 8'h00;
  localparam logic [7:0] IN_CFG_LAST  = 8'h0C;
  localparam logic [7:0] OUT_CFG0     = 8'h10;
  localparam logic [7:0] OUT_CFG_LAST = 8'h24;
  localparam logic [7:0] PROT_NOREC   = 8'h28;
  localparam logic [7:0] PROT_ACTIVE  = 8'h2C;
  localparam logic [7:0] FUNC_STATUS  = 8'h30;
  localparam logic [7:0] IRQ_STATUS   = 8'h34;
  localparam logic [7:0] IRQ_CLEAR    = 8'h38;
  localparam logic [7:0] IRQ_ENABLE   = 8'h3C;
  localparam logic [7:0] PROT_CLEAR   = 8'h40;

  ////////////////////////////////////////////////////////////////////////
  // pin config fields
  localparam int FN_LSB    = 0;
  localparam int FN_W      = 2;
  localparam int INV_BIT   = 2;
  localparam int SENSE_BIT = 3;
  localparam int IN_CFG_W  = 4;
  localparam int OUT_CFG_W = 3;
  localparam int CLR_BIT   = 0;

  // reset values: default function per pin, no inversion, voltage sensing
  localparam logic [15:0] IN_CFG_RST  = 16'h0321;
  localparam logic [17:0] OUT_CFG_RST = 18'h000D1;
  localparam logic [4:0]  IRQ_EN_RST  = 5'h00;

  ////////////////////////////////////////////////////////////////////////
  // interrupt and function status bits
  localparam int IRQ_PROT_SET  = 0;
  localparam int IRQ_PIN_CLR   = 1;
  localparam int IRQ_REJECT    = 2;
  localparam int IRQ_IGN_CHG   = 3;
  localparam int IRQ_MAINS_CHG = 4;
  localparam int IRQ_W         = 5;
  localparam int ST_W          = 5;

  ////////////////////////////////////////////////////////////////////////
  // function codes, none first so a zero config is unassigned
  typedef enum logic [1:0] {IN_NONE, IN_IGNITION, IN_MAINS, IN_PROT_CLR} rpm_in_func_type;
  typedef enum logic [1:0] {OUT_NONE, OUT_CHG_IND, OUT_CHG_EN, OUT_PROT_IND} rpm_out_func_type;

endpackage

// ===== verification/rpm_far_model.sv
// far side of the pin mux: sense switches on the inputs, pull-ups on the outputs
// assumes the pad resolves the open-drain level from the enable alone
`timescale 1ns/100ps
`default_nettype none
module rpm_far_model (
  // sense stage side
  input  wire logic [3:0] pullup_en,
  input  wire logic [3:0] ext_volt,
  input  wire logic [3:0] ext_gnd,
  output logic      [3:0] gpi_level,
  // output pads
  input  wire logic [5:0] gpo_oe,
  output logic      [5:0] gpo_pad
);
  // ground sensing reads a floating pin high through the pull-up, voltage sensing needs a source
  assign gpi_level = (pullup_en & ~ext_gnd) | (~pullup_en & ext_volt);
  // released pad returns to the pull-up level, never driven high by the mux
  assign gpo_pad   = ~gpo_oe;
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench of the pin mux with a far side model
// assumes one 50 MHz clock and strobe register port, no random stimulus
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_top;
  logic        sys_clk = 1'b0;    // system clock
  logic        rst = 1'b1;        // async reset
  logic [7:0]  reg_addr = 8'h00;  // register port
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata, rd;
  logic [3:0]  gpi_in, pu, ext_volt = 4'h0, ext_gnd = 4'h0;
  logic [5:0]  gpo_o, gpo_oe, pad;
  logic [7:0]  prot_event = 8'h00, prot_recover = 8'h00;
  logic        charge_request = 1'b0, charging_active = 1'b0;
  logic        ignition_state, mains_present_input, prot_any, charger_en, irq;
  int          err_count = 0, check_count = 0, cyc_count = 0;
  always #10 sys_clk = ~sys_clk;
  rpm_mux #(.NPROT(8)) dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpi_in(gpi_in), .gpi_pullup_en(pu),
    .gpo_o(gpo_o), .gpo_oe(gpo_oe), .prot_event(prot_event), .prot_recover(prot_recover),
    .charge_request(charge_request), .charging_active(charging_active), .ignition_state(ignition_state),
    .mains_present_input(mains_present_input), .prot_any(prot_any), .charger_en(charger_en), .irq(irq));
  rpm_far_model far (.pullup_en(pu), .ext_volt(ext_volt), .ext_gnd(ext_gnd), .gpi_level(gpi_in),
    .gpo_oe(gpo_oe), .gpo_pad(pad));
  ////////////////////////////////////////////////////////////////////////
  // bus and timing helpers; settle 1 ns past the edge before looking
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
    @(posedge sys_clk) reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk) begin reg_rd <= 1'b1; reg_addr <= a; end
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // reset mapping and unmapped address
  task automatic t_defaults();
    for (int i = 0; i < 4; i++) begin
      reg_read(8'(4 * i), rd);
      `CHK("in_cfg", {28'h0, rpm_pkg::IN_CFG_RST[4*i+:4]}, rd)
    end
    for (int i = 0; i < 6; i++) begin
      reg_read(8'h10 + 8'(4 * i), rd);
      `CHK("out_cfg", {29'h0, rpm_pkg::OUT_CFG_RST[3*i+:3]}, rd)
    end
    reg_read(8'h44, rd);
    `CHK("unmapped", 32'h0, rd)
    $display("test defaults done");
  endtask
  // sensing styles and inversion on the ignition pin, then mains
  task automatic t_inputs();
    @(posedge sys_clk) ext_volt <= 4'h1;
    cyc(5);
    `CHK("ign volt", 1'b1, ignition_state)
    reg_write(rpm_pkg::IN_CFG0, 32'h9);
    cyc(6);
    `CHK("pullup", 4'h1, pu)
    `CHK("ign float", 1'b1, ignition_state)
    @(posedge sys_clk) ext_gnd <= 4'h1;
    cyc(5);
    `CHK("ign gnd", 1'b0, ignition_state)
    reg_write(rpm_pkg::IN_CFG0, 32'hD);
    cyc(6);
    `CHK("ign inv", 1'b1, ignition_state)
    reg_write(rpm_pkg::IN_CFG0, 32'h1);
    @(posedge sys_clk) ext_volt <= 4'h3;
    cyc(5);
    `CHK("mains", 1'b1, mains_present_input)
    reg_read(rpm_pkg::FUNC_STATUS, rd);
    `CHK("status", 2'h3, rd[1:0])
    $display("test inputs done");
  endtask
  // duplicate function refused, raises a masked then enabled interrupt
  task automatic t_unique();
    reg_write(8'h0C, 32'h1);
    reg_write(8'h1C, 32'h2);
    reg_read(8'h0C, rd);
    `CHK("dup in", 32'h0, rd)
    reg_read(8'h1C, rd);
    `CHK("dup out", 32'h0, rd)
    reg_read(rpm_pkg::IRQ_STATUS, rd);
    `CHK("reject", 1'b1, rd[2])
    `CHK("irq off", 1'b0, irq)
    reg_write(rpm_pkg::IRQ_ENABLE, 32'h4);
    cyc(1);
    `CHK("irq on", 1'b1, irq)
    reg_write(rpm_pkg::IRQ_CLEAR, 32'h4);
    cyc(1);
    `CHK("irq clr", 1'b0, irq)
    $display("test unique done");
  endtask
  // latched and self-recovering protections, indication, charger gating, clear pin and clear register
  task automatic t_prot();
    reg_write(rpm_pkg::PROT_NOREC, 32'h1);
    @(posedge sys_clk) begin charge_request <= 1'b1; prot_recover <= 8'hFF; prot_event <= 8'h03; end
    @(posedge sys_clk) prot_event <= 8'h00;
    cyc(8);
    `CHK("prot", 1'b1, prot_any)
    `CHK("ind pad", 1'b0, pad[2])
    `CHK("chg off", 1'b0, charger_en)
    `CHK("en pad off", 1'b1, pad[1])
    reg_read(rpm_pkg::PROT_ACTIVE, rd);
    `CHK("norec held", 32'h1, rd)
    @(posedge sys_clk) ext_volt <= 4'h7;
    cyc(6);
    `CHK("cleared", 1'b0, prot_any)
    `CHK("chg on", 1'b1, charger_en)
    `CHK("ind rel", 1'b1, pad[2])
    `CHK("en pad on", 1'b0, pad[1])
    `CHK("od", 6'h00, gpo_o)
    reg_read(rpm_pkg::IRQ_STATUS, rd);
    `CHK("clr irq", 2'h3, rd[1:0])
    @(posedge sys_clk) prot_event <= 8'h01;
    @(posedge sys_clk) prot_event <= 8'h00;
    cyc(2);
    `CHK("prot again", 1'b1, prot_any)
    reg_write(rpm_pkg::PROT_CLEAR, 32'h1);
    cyc(1);
    `CHK("sw clear", 1'b0, prot_any)
    $display("test prot done");
  endtask
  // charging indication and moving it to another pin
  task automatic t_outputs();
    @(posedge sys_clk) charging_active <= 1'b1;
    cyc(3);
    `CHK("chg ind", 1'b0, pad[0])
    reg_write(rpm_pkg::OUT_CFG0, 32'h0);
    cyc(2);
    `CHK("unassigned", 1'b1, pad[0])
    reg_write(8'h20, 32'h1);
    cyc(2);
    `CHK("moved", 1'b0, pad[4])
    reg_write(8'h20, 32'h5);
    cyc(2);
    `CHK("out inv", 1'b1, pad[4])
    $display("test outputs done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // hang guard, well past the roughly 130 cycles the tests need
  always @(posedge sys_clk) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 3000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    t_defaults();
    t_inputs();
    t_unique();
    t_prot();
    t_outputs();
    test_done();
  end
endmodule
`default_nettype wire
